/* File: logic/shp_host_port.sv */
// Purpose: Host data/status port, status word, stack and interrupt entry.
// Assumes: Host strobes are asynchronous pins; the program side is a
//          one-instruction-per-cycle stream with instrValid/instrStall.
// Notes:   Each rule below is tagged at the logic that carries it out.
`timescale 1ns/100ps
`default_nettype none
module shp_host_port (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        clkEn,
   input  wire logic        chipSelect_n,
   input  wire logic        readStrobe_n,
   input  wire logic        writeStrobe_n,
   input  wire logic        registerSelectLine,
   input  wire logic [7:0]  hostDataIn,
   output logic      [7:0]  hostDataOut,
   output logic             hostDataOe,
   input  wire logic        instrValid,
   input  wire logic [7:0]  instrOpcode,
   input  wire logic [7:0]  accumulator,
   input  wire logic [7:0]  aluOperand,
   input  wire logic [10:0] programCounter,
   input  wire logic        timerOverflow,
   output logic             instrStall,
   output logic      [7:0]  accumulatorLoad,
   output logic             accumulatorLoadValid,
   output logic             pcLoadValid,
   output logic      [10:0] pcLoad,
   output logic      [7:0]  programStatusWord,
   output logic             commandFlag,
   output logic             port2Bit4Pin,
   output logic             port2Bit5Pin,
   input  wire logic        flagPinEnable
);
   // Two-stage synchronisers for the host strobes and address, plus a third stage for edge detection.
   logic [3:0] syncA, syncB, syncC;
   logic [7:0] dataA, dataB, dataC;
   logic       rdAct, wrAct, rdPrev, wrPrev, rdRise, wrRise;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= 4'hF;
         syncB <= 4'hF;
         syncC <= 4'hF;
         dataA <= 8'h00;
         dataB <= 8'h00;
         dataC <= 8'h00;
      end else if (clkEn) begin
         syncA <= {chipSelect_n, readStrobe_n, writeStrobe_n, registerSelectLine};
         syncB <= syncA;
         syncC <= syncB;
         dataA <= hostDataIn;
         dataB <= dataA;
         dataC <= dataB;
      end
   end

   always_comb begin
      rdAct  = !syncB[3] && !syncB[2] && syncB[1];
      wrAct  = !syncB[3] && syncB[2] && !syncB[1];
      rdPrev = !syncC[3] && !syncC[2] && syncC[1];
      wrPrev = !syncC[3] && syncC[2] && !syncC[1];
      rdRise = rdPrev && !rdAct;
      wrRise = wrPrev && !wrAct;
   end

   // Host writes are queued so the program side can lag behind.
   // The byte is taken at the same depth as the older strobe sample, so it is
   // the value that stood while the write strobe was still low.
   logic       fifoInReady, fifoOutValid, fifoOutReady;
   logic [8:0] fifoOutData;

   shp_fifo #(.WIDTH(9), .DEPTH(shp_pkg::FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .inValid  (wrRise),
      .inReady  (fifoInReady),
      .inData   ({syncC[0], dataC}),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // Port, flag and interrupt state.
   logic [7:0]  outBuf, next_outBuf;
   logic [7:0]  inBuf, next_inBuf;
   logic        outFull, next_outFull;
   logic        inFull, next_inFull;
   logic [7:0]  program_status_word, next_psw;
   logic [3:0]  stsUpper, next_stsUpper;
   logic        flag1, next_flag1;
   logic        inService, next_inService;
   logic        inIntEn, next_inIntEn;
   logic        tmIntEn, next_tmIntEn;
   logic        tmPending, next_tmPending;
   logic        pinEn, next_pinEn;
   logic [7:0]  stackRam [shp_pkg::STACK_BYTES];
   logic [7:0]  next_dataOut;
   logic        next_dataOe;
   logic [10:0] next_pcLoad;
   logic        next_pcLoadValid;
   logic [7:0]  next_accLoad;
   logic        next_accLoadValid;
   logic        stkWr;
   logic [3:0]  stkWrIdx;
   logic [7:0]  stkLo, stkHi;
   logic [8:0]  sum;
   logic [4:0]  halfSum;
   logic [2:0]  popSp;
   logic [7:0]  pushAddr, popAddr;
   logic        next_stall;
   shp_pkg::shp_state_t state, next_state;

   function automatic logic [7:0] stack_addr(input logic [2:0] sp);
      stack_addr = {shp_pkg::STACK_BASE, sp};
   endfunction : stack_addr

   function automatic logic [7:0] host_status(input logic [3:0] up, input logic f0,
                                              input logic f1, input logic input_full_flag,
                                              input logic output_full_flag);
      host_status = {up, f1, f0, input_full_flag, output_full_flag};
   endfunction : host_status

   always_comb begin
      next_outBuf       = outBuf;
      next_inBuf        = inBuf;
      next_outFull      = outFull;
      next_inFull       = inFull;
      next_psw          = program_status_word;
      next_stsUpper     = stsUpper;
      next_flag1        = flag1;
      next_inService    = inService;
      next_inIntEn      = inIntEn;
      next_tmIntEn      = tmIntEn;
      next_tmPending    = tmPending;
      next_pinEn        = pinEn | flagPinEnable;
      next_state        = state;
      next_pcLoad       = pcLoad;
      next_pcLoadValid  = 1'b0;
      next_accLoad      = accumulatorLoad;
      next_accLoadValid = 1'b0;
      stkWr             = 1'b0;
      stkWrIdx          = 4'h0;
      stkLo             = 8'h00;
      stkHi             = 8'h00;
      fifoOutReady      = 1'b0;
      popSp             = program_status_word[2:0] - 3'h1;
      pushAddr          = stack_addr(program_status_word[2:0]);
      popAddr           = stack_addr(popSp);
      sum               = {1'b0, accumulator} + {1'b0, aluOperand};
      halfSum           = {1'b0, accumulator[3:0]} + {1'b0, aluOperand[3:0]};

      // Host read: output buffer or status byte.
      next_dataOe  = rdAct;
      next_dataOut = (syncB[0] == shp_pkg::SEL_STATUS) ?
                     host_status(stsUpper, program_status_word[shp_pkg::PSW_FLAG0], flag1, inFull, outFull) :
                     outBuf;
      if (rdRise && syncC[0] == shp_pkg::SEL_DATA) begin
         next_outFull = 1'b0;
      end

      // Drain one queued host byte when the input buffer is free.
      if (fifoOutValid && !inFull) begin
         fifoOutReady = 1'b1;
         next_inBuf   = fifoOutData[7:0];
         next_inFull  = 1'b1;
         next_flag1   = fifoOutData[8];
      end

      case (state)
         shp_pkg::SHP_IDLE: begin
            if (instrValid) begin
               case (instrOpcode)
                  shp_pkg::OP_BUF_WRITE: begin
                     next_outBuf  = accumulator;
                     next_outFull = 1'b1;
                  end
                  shp_pkg::OP_BUF_READ: begin
                     next_accLoad      = inBuf;
                     next_accLoadValid = 1'b1;
                     if (!(fifoOutValid && !inFull)) begin
                        next_inFull = 1'b0;
                     end
                  end
                  shp_pkg::OP_STS_WRITE: next_stsUpper = accumulator[7:4];
                  shp_pkg::OP_ADD: begin
                     next_psw[shp_pkg::PSW_CARRY] = sum[8];
                     next_psw[shp_pkg::PSW_HALF]  = halfSum[4];
                  end
                  shp_pkg::OP_PSW_WRITE: next_psw = {accumulator[7:4], 1'b1, accumulator[2:0]};
                  shp_pkg::OP_CLR_F0: next_psw[shp_pkg::PSW_FLAG0] = 1'b0;
                  shp_pkg::OP_CPL_F0: next_psw[shp_pkg::PSW_FLAG0] = !program_status_word[shp_pkg::PSW_FLAG0];
                  shp_pkg::OP_BANK0: next_psw[shp_pkg::PSW_BANK] = 1'b0;
                  shp_pkg::OP_BANK1: next_psw[shp_pkg::PSW_BANK] = 1'b1;
                  shp_pkg::OP_IN_INT_EN:  next_inIntEn = 1'b1;
                  shp_pkg::OP_IN_INT_DIS: next_inIntEn = 1'b0;
                  shp_pkg::OP_TM_INT_EN:  next_tmIntEn = 1'b1;
                  shp_pkg::OP_TM_INT_DIS: next_tmIntEn = 1'b0;
                  shp_pkg::OP_FLAG_EN:    next_pinEn   = 1'b1;
                  shp_pkg::OP_RET_REST:   next_state   = shp_pkg::SHP_POP;
                  default: ;
               endcase
            end
            // Interrupts are taken only at an instruction boundary.
            if (!instrValid && !inService) begin
               if (inIntEn && inFull) begin
                  next_state     = shp_pkg::SHP_PUSH;
                  next_inService = 1'b1;
                  next_pcLoad    = shp_pkg::VEC_INPUT;
               end else if (tmIntEn && tmPending) begin
                  next_state     = shp_pkg::SHP_PUSH;
                  next_inService = 1'b1;
                  next_tmPending = 1'b0;
                  next_pcLoad    = shp_pkg::VEC_TIMER;
               end
            end
         end
         shp_pkg::SHP_PUSH: begin
            stkWr    = 1'b1;
            stkWrIdx = {pushAddr[2:0], 1'b0};
            stkLo    = programCounter[7:0];
            stkHi    = {program_status_word[7:4], 1'b0, programCounter[10:8]};
            next_psw[2:0]    = program_status_word[2:0] + 3'h1;
            next_pcLoadValid = 1'b1;
            next_state       = shp_pkg::SHP_IDLE;
         end
         shp_pkg::SHP_POP: begin
            next_psw[2:0]    = popSp;
            next_psw[7:4]    = stackRam[{popAddr[2:0], 1'b1}][7:4];
            next_pcLoad      = {stackRam[{popAddr[2:0], 1'b1}][2:0],
                                stackRam[{popAddr[2:0], 1'b0}]};
            next_pcLoadValid = 1'b1;
            next_inService   = 1'b0;
            next_state       = shp_pkg::SHP_IDLE;
         end
         default: next_state = shp_pkg::SHP_IDLE;
      endcase

      // The set comes last so an overflow in the acceptance cycle is kept.
      if (timerOverflow) begin
         next_tmPending = 1'b1;
      end
      next_stall = (next_state != shp_pkg::SHP_IDLE);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outBuf               <= shp_pkg::BYTE_RESET;
         inBuf                <= shp_pkg::BYTE_RESET;
         outFull              <= 1'b0;
         inFull               <= 1'b0;
         program_status_word                  <= shp_pkg::PSW_RESET;
         stsUpper             <= 4'h0;
         flag1                <= 1'b0;
         inService            <= 1'b0;
         inIntEn              <= 1'b0;
         tmIntEn              <= 1'b0;
         tmPending            <= 1'b0;
         pinEn                <= 1'b0;
         state                <= shp_pkg::SHP_IDLE;
         hostDataOut          <= shp_pkg::BYTE_RESET;
         hostDataOe           <= 1'b0;
         pcLoad               <= shp_pkg::PC_RESET;
         pcLoadValid          <= 1'b0;
         accumulatorLoad      <= shp_pkg::BYTE_RESET;
         accumulatorLoadValid <= 1'b0;
         programStatusWord    <= shp_pkg::PSW_RESET;
         commandFlag          <= 1'b0;
         port2Bit4Pin         <= 1'b0;
         port2Bit5Pin         <= 1'b0;
         instrStall           <= 1'b0;
      end else if (clkEn) begin
         outBuf               <= next_outBuf;
         inBuf                <= next_inBuf;
         outFull              <= next_outFull;
         inFull               <= next_inFull;
         program_status_word                  <= next_psw;
         stsUpper             <= next_stsUpper;
         flag1                <= next_flag1;
         inService            <= next_inService;
         inIntEn              <= next_inIntEn;
         tmIntEn              <= next_tmIntEn;
         tmPending            <= next_tmPending;
         pinEn                <= next_pinEn;
         state                <= next_state;
         hostDataOut          <= next_dataOut;
         hostDataOe           <= next_dataOe;
         pcLoad               <= next_pcLoad;
         pcLoadValid          <= next_pcLoadValid;
         accumulatorLoad      <= next_accLoad;
         accumulatorLoadValid <= next_accLoadValid;
         programStatusWord    <= next_psw;
         commandFlag          <= next_flag1;
         port2Bit4Pin         <= next_pinEn & next_outFull;
         port2Bit5Pin         <= next_pinEn & next_inFull;
         instrStall           <= next_stall;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn && stkWr) begin
         stackRam[stkWrIdx]        <= stkLo;
         stackRam[stkWrIdx + 4'h1] <= stkHi;
      end
   end

   // Assertions.
   buf_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && state == shp_pkg::SHP_IDLE && instrValid && instrOpcode == shp_pkg::OP_BUF_WRITE
      |=> outFull && outBuf == $past(accumulator))
      else $error("buffer write did not load and flag");
   host_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && rdRise && syncC[0] == shp_pkg::SEL_DATA && !(state == shp_pkg::SHP_IDLE
      && instrValid && instrOpcode == shp_pkg::OP_BUF_WRITE) |=> !outFull)
      else $error("host read left output-full set");
   status_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && rdRise && syncC[0] == shp_pkg::SEL_STATUS && !instrValid && !fifoOutValid
      |=> outFull == $past(outFull) && inFull == $past(inFull))
      else $error("status read changed a flag");
   read_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && rdAct |=> hostDataOe)
      else $error("read cycle not driven");
   fifo_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && fifoOutValid && !inFull |=> inFull && flag1 == $past(fifoOutData[8]))
      else $error("queued host byte not loaded");
   stack_push_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && state == shp_pkg::SHP_PUSH |=> program_status_word[2:0] == $past(program_status_word[2:0]) + 3'h1 && pcLoadValid)
      else $error("interrupt entry did not push");
   return_pop_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && state == shp_pkg::SHP_POP |=> !inService && program_status_word[2:0] == $past(popSp))
      else $error("return did not restore");
   int_priority_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && state == shp_pkg::SHP_IDLE && !instrValid && !inService && inIntEn && inFull
      |=> pcLoad == shp_pkg::VEC_INPUT && inService)
      else $error("input interrupt lost priority");
   timer_pend_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && timerOverflow |=> tmPending)
      else $error("timer overflow not latched");
   bank_select_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && state == shp_pkg::SHP_IDLE && instrValid && instrOpcode == shp_pkg::OP_BANK1
      |=> program_status_word[shp_pkg::PSW_BANK])
      else $error("bank one not selected");
   flag_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn && pinEn |=> port2Bit4Pin == outFull && port2Bit5Pin == inFull)
      else $error("flag pins do not follow the buffer flags");
   stall_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      clkEn |=> instrStall == (state != shp_pkg::SHP_IDLE))
      else $error("stall does not cover push or pop");
endmodule : shp_host_port
`default_nettype wire

/* File: logic/shp_pkg.sv */
// Purpose: Shared constants for the slave host port with interrupts.
// Assumes: One 40 MHz clock, asynchronous active-low reset.
// Notes:   Status field positions, vectors and the PSW, byte and PC reset values live here.
package shp_pkg;
   localparam int          DATA_W        = 8;
   localparam int          FIFO_DEPTH    = 4;
   localparam int          PC_W          = 11;
   // Status word field positions.
   localparam int          PSW_CARRY     = 7;
   localparam int          PSW_HALF      = 6;
   localparam int          PSW_FLAG0     = 5;
   localparam int          PSW_BANK      = 4;
   localparam int          PSW_SP_LSB    = 0;
   localparam int          SP_W          = 3;
   // Host status byte field positions.
   localparam int          STS_OUT_FULL  = 0;
   localparam int          STS_IN_FULL   = 1;
   localparam int          STS_FLAG0     = 2;
   localparam int          STS_FLAG1     = 3;
   // Stack address: upper five bits fixed.
   localparam logic [4:0]  STACK_BASE    = 5'h01;
   localparam int          STACK_BYTES   = 16;
   // Interrupt vectors.
   localparam logic [10:0] VEC_INPUT     = 11'h003;
   localparam logic [10:0] VEC_TIMER     = 11'h007;
   // Reset values.
   localparam logic [7:0]  PSW_RESET     = 8'h08;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [10:0] PC_RESET      = 11'h000;
   // Host address line values.
   localparam logic        SEL_DATA      = 1'b0;
   localparam logic        SEL_STATUS    = 1'b1;
   // Internal program instruction opcodes.
   localparam logic [7:0]  OP_BUF_WRITE  = 8'h02;
   localparam logic [7:0]  OP_BUF_READ   = 8'h22;
   localparam logic [7:0]  OP_STS_WRITE  = 8'h90;
   localparam logic [7:0]  OP_RET_REST   = 8'h93;
   localparam logic [7:0]  OP_FLAG_EN    = 8'hF5;
   localparam logic [7:0]  OP_IN_INT_EN  = 8'h05;
   localparam logic [7:0]  OP_IN_INT_DIS = 8'h15;
   localparam logic [7:0]  OP_TM_INT_EN  = 8'h25;
   localparam logic [7:0]  OP_TM_INT_DIS = 8'h35;
   localparam logic [7:0]  OP_BANK0      = 8'hC5;
   localparam logic [7:0]  OP_BANK1      = 8'hD5;
   localparam logic [7:0]  OP_ADD        = 8'h03;
   localparam logic [7:0]  OP_PSW_WRITE  = 8'hD7;
   localparam logic [7:0]  OP_CLR_F0     = 8'h85;
   localparam logic [7:0]  OP_CPL_F0     = 8'h95;

   typedef enum logic [2:0] {
      SHP_IDLE  = 3'b001,
      SHP_PUSH  = 3'b010,
      SHP_POP   = 3'b100
   } shp_state_t;
endpackage : shp_pkg

/* File: logic/shp_fifo.sv */
// Purpose: Small flip-flop FIFO carrying host-written bytes.
// Assumes: Same clock as the port; write ignored while full.
// Notes:   Width and depth shape the storage array.
`timescale 1ns/100ps
`default_nettype none
module shp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clkEn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr,  next_wrPtr;
   logic [AW-1:0]    rdPtr,  next_rdPtr;
   logic [AW:0]      count,  next_count;
   logic             doWr,   doRd;

   always_comb begin
      inReady    = (count != DEPTH[AW:0]);
      outValid   = (count != '0);
      outData    = mem[rdPtr];
      doWr       = inValid && inReady;
      doRd       = outValid && outReady;
      next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
      next_count = count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (clkEn) begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn && doWr) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule : shp_fifo
`default_nettype wire

/* File: tb/shp_host_master.sv */
// Purpose: Master processor model on the parallel host bus.
// Assumes: Pins change just after a falling clock edge.
// Notes:   Undriven data lines show the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none
module shp_host_master (
   input  wire logic       clk,
   input  wire logic [7:0] devData,
   input  wire logic       devOe,
   output logic            chipSel_n,
   output logic            rdStrobe_n,
   output logic            wrStrobe_n,
   output logic            regSel,
   output logic      [7:0] busData
);
   initial begin
      chipSel_n  = 1'b1;
      rdStrobe_n = 1'b1;
      wrStrobe_n = 1'b1;
      regSel     = 1'b0;
      busData    = 8'h00;
   end
   task automatic wr(input logic sel, input logic [7:0] d);
      @(negedge clk);
      chipSel_n  = 1'b0;
      regSel     = sel;
      busData    = d;
      wrStrobe_n = 1'b0;
      repeat (4) @(negedge clk);
      wrStrobe_n = 1'b1;
      chipSel_n  = 1'b1;
      busData    = ~d;
      repeat (6) @(negedge clk);
   endtask : wr
   task automatic rd(input logic sel, output logic [7:0] d);
      @(negedge clk);
      chipSel_n  = 1'b0;
      regSel     = sel;
      rdStrobe_n = 1'b0;
      repeat (5) @(negedge clk);
      d          = devOe ? devData : ~devData;
      rdStrobe_n = 1'b1;
      chipSel_n  = 1'b1;
      repeat (5) @(negedge clk);
   endtask : rd
endmodule : shp_host_master
`default_nettype wire

/* File: tb/shp_host_port_tb.sv */
// Purpose: Self-checking bench for the host port block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Seeded random data mixed with fixed corner cases.
`timescale 1ns/100ps
`default_nettype none
module shp_host_port_tb;
   logic        clk = 1'b0, reset_n = 1'b0, valid = 1'b0, tmr = 1'b0, pinEn = 1'b0, en = 1'b1;
   logic        cs_n, rd_n, wr_n, sel, oe, stall, accV, pcV, cmd, pin4, pin5;
   logic [7:0]  opc = 8'h00, acc = 8'h00, opB = 8'h00, hIn, hOut, accLd, program_status_word, d, a, b;
   logic [10:0] pc = 11'h000, pcLd;
   int          fails = 0, samplesChecked = 0;
   logic [7:0]  q[$];
   always #12.5 clk = ~clk;
   shp_host_master host (.clk(clk), .devData(hOut), .devOe(oe), .chipSel_n(cs_n),
      .rdStrobe_n(rd_n), .wrStrobe_n(wr_n), .regSel(sel), .busData(hIn));
   shp_host_port uut (.clk(clk), .reset_n(reset_n), .clkEn(en), .chipSelect_n(cs_n),
      .readStrobe_n(rd_n), .writeStrobe_n(wr_n), .registerSelectLine(sel),
      .hostDataIn(hIn), .hostDataOut(hOut), .hostDataOe(oe), .instrValid(valid),
      .instrOpcode(opc), .accumulator(acc), .aluOperand(opB), .programCounter(pc),
      .timerOverflow(tmr), .instrStall(stall), .accumulatorLoad(accLd),
      .accumulatorLoadValid(accV), .pcLoadValid(pcV), .pcLoad(pcLd),
      .programStatusWord(program_status_word), .commandFlag(cmd), .port2Bit4Pin(pin4),
      .port2Bit5Pin(pin5), .flagPinEnable(pinEn));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [11:0] got, exp);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic guard(input int n);
      if (n == 60) begin
         fails++;
         report_and_stop();
      end
   endtask : guard
   task automatic waitPulse(input logic which, input logic [10:0] exp);
      for (int n = 0; (which ? accV : pcV) !== 1'b1; n++) begin
         guard(n);
         @(negedge clk);
      end
      chk(which ? 11'(accLd) : pcLd, exp);
   endtask : waitPulse
   task automatic exec(input logic [7:0] o, x);
      @(negedge clk);
      for (int n = 0; stall !== 1'b0; n++) begin
         guard(n);
         @(negedge clk);
      end
      opc   = o;
      acc   = x;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
   endtask : exec
   task automatic stat(input logic [7:0] e);
      host.rd(shp_pkg::SEL_STATUS, d);
      chk(d, e);
   endtask : stat
   function automatic logic [1:0] addFlags(input logic [7:0] x, y);
      return {9'(x) + 9'(y) > 9'h0FF, 5'(x[3:0]) + 5'(y[3:0]) > 5'h0F};
   endfunction : addFlags
   initial begin
      void'($urandom(32'hAEC9E36C));
      pc = 11'($urandom);
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      chk(program_status_word, shp_pkg::PSW_RESET);
      stat(8'h00);
      a = 8'($urandom);
      exec(shp_pkg::OP_BUF_WRITE, a);
      chk(pin4, 1'b0);
      exec(shp_pkg::OP_FLAG_EN, 8'h00);
      stat(8'h01);
      stat(8'h01);
      chk(pin4, 1'b1);
      host.rd(shp_pkg::SEL_DATA, d);
      chk(d, a);
      stat(8'h00);
      b = 8'($urandom);
      host.wr(shp_pkg::SEL_DATA, b);
      chk({pin5, cmd}, 2'b10);
      exec(shp_pkg::OP_CPL_F0, 8'h00);
      exec(shp_pkg::OP_STS_WRITE, a);
      stat({a[7:4], 4'h6});
      exec(shp_pkg::OP_BUF_READ, 8'h00);
      waitPulse(1'b1, b);
      chk(pin5, 1'b0);
      exec(shp_pkg::OP_BANK1, 8'h00);
      chk(program_status_word[4], 1'b1);
      @(negedge clk);
      en    = 1'b0;
      opc   = shp_pkg::OP_BANK0;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      en    = 1'b1;
      chk(program_status_word[4], 1'b1);
      exec(shp_pkg::OP_BANK0, 8'h00);
      chk(program_status_word[4], 1'b0);
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 8'h0F : (i == 1) ? 8'hF0 : 8'($urandom);
         opB = (i == 0) ? 8'h01 : (i == 1) ? 8'h10 : 8'($urandom);
         exec(shp_pkg::OP_ADD, a);
         chk(program_status_word[7:6], addFlags(a, opB));
      end
      // One byte sits in the buffer and four queue; the sixth must be dropped.
      for (int i = 0; i < 6; i++) begin
         q.push_back(8'($urandom));
         host.wr(shp_pkg::SEL_DATA, q[i]);
      end
      for (int i = 0; i < 5; i++) begin
         exec(shp_pkg::OP_BUF_READ, 8'h00);
         waitPulse(1'b1, q[i]);
      end
      chk(pin5, 1'b0);
      tmr = 1'b1;
      @(negedge clk);
      tmr = 1'b0;
      host.wr(shp_pkg::SEL_STATUS, b);
      chk(cmd, 1'b1);
      d     = program_status_word;
      opc   = shp_pkg::OP_IN_INT_EN;
      valid = 1'b1;
      @(negedge clk);
      opc = shp_pkg::OP_TM_INT_EN;
      @(negedge clk);
      valid = 1'b0;
      waitPulse(1'b0, shp_pkg::VEC_INPUT);
      repeat (2) @(negedge clk);
      chk(program_status_word[2:0], 3'h1);
      exec(shp_pkg::OP_BUF_READ, 8'h00);
      waitPulse(1'b1, b);
      exec(shp_pkg::OP_RET_REST, 8'h00);
      waitPulse(1'b0, pc);
      @(negedge clk);
      waitPulse(1'b0, shp_pkg::VEC_TIMER);
      exec(shp_pkg::OP_RET_REST, 8'h00);
      waitPulse(1'b0, pc);
      repeat (2) @(negedge clk);
      chk(program_status_word, d);
      report_and_stop();
   end
endmodule : shp_host_port_tb
`default_nettype wire
